// ==== verilog/rcf_consts.vh ====
// Purpose: Constants for the reset-cause flag block.
// Assumes: Avalon-MM slave, 32-bit data, word addresses.
// Notes: Offsets are word indices that the top compares directly with avs_address; RCF_OFF_CTRL is not decoded.
`ifndef RCF_CONSTS_VH
`define RCF_CONSTS_VH
`define RCF_ADDR_W 4
`define RCF_OFF_CAUSE 4'h0
`define RCF_OFF_CTRL 4'h1
`define RCF_OFF_IRQ_STAT 4'h2
`define RCF_OFF_IRQ_CLR 4'h3
`define RCF_OFF_IRQ_EN 4'h4
`define RCF_BIT_PRIO 7
`define RCF_BIT_SWBO 6
`define RCF_BIT_RI 4
`define RCF_BIT_WDT 3
`define RCF_BIT_SLP 2
`define RCF_BIT_POR 1
`define RCF_BIT_BO 0
`define RCF_CAUSE_WMASK 8'hd3
`define RCF_BO_CFG_SW 2'h1
`define RCF_EVT_W 5
`endif

// ==== verilog/rcf_flag.v ====
// Purpose: One reset-cause flag bit with hardware set/clear and software write.
// Assumes: Hardware event wins over a software write in the same cycle.
// Notes: Hardware clear has priority over hardware set.
`timescale 1ns/10ps
`default_nettype none
module rcf_flag #(
    parameter RST_VAL = 1'b1
) (
    input wire clk_sys,
    input wire rst,
    input wire hw_set,
    input wire hw_clr,
    input wire sw_we,
    input wire sw_val,
    output reg flag_reg
);
    // Hardware events beat software writes so no event is lost.
    always @(posedge clk_sys) begin
        if (rst) begin
            flag_reg <= RST_VAL;
        end else if (hw_clr) begin
            flag_reg <= 1'b0;
        end else if (hw_set) begin
            flag_reg <= 1'b1;
        end else if (sw_we) begin
            flag_reg <= sw_val;
        end
    end
endmodule
`default_nettype wire

// ==== verilog/rcf_irq.v ====
// Purpose: Sticky event status, enable, write-one-to-clear, level interrupt.
// Assumes: Set wins over clear in the same cycle.
// Notes: Output comes from a flip-flop.
`timescale 1ns/10ps
`default_nettype none
module rcf_irq #(
    parameter W = 5
) (
    input wire clk_sys,
    input wire rst,
    input wire [W-1:0] evt,
    input wire [W-1:0] clr,
    input wire en_we,
    input wire [W-1:0] en_val,
    output reg [W-1:0] stat_reg,
    output reg [W-1:0] en_reg,
    output reg irq_reg
);
    wire [W-1:0] stat_next;
    // A new event re-sets a bit even while software clears it.
    assign stat_next = (stat_reg & ~clr) | evt;
    always @(posedge clk_sys) begin
        if (rst) begin
            stat_reg <= {W{1'b0}};
            en_reg <= {W{1'b0}};
            irq_reg <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            if (en_we) begin
                en_reg <= en_val;
            end
            irq_reg <= |(stat_next & (en_we ? en_val : en_reg));
        end
    end
endmodule
`default_nettype wire

// ==== verilog/rcf_top.v ====
// Purpose: Reset-cause status register with Avalon-MM access and interrupt.
// Assumes: Cause inputs are one-cycle pulses synchronous to clk_sys.
// Notes: rst reloads every flag; the kind of device reset is given by cause pulses.
`timescale 1ns/10ps
`default_nettype none
`include "rcf_consts.vh"
module rcf_top (
    input wire clk_sys,
    input wire rst,
    input wire [`RCF_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire power_on_evt,
    input wire brownout_evt,
    input wire reset_instr_evt,
    input wire watchdog_timeout_evt,
    input wire watchdog_clear_instr,
    input wire sleep_instr,
    input wire [1:0] brownout_config_bits,
    output reg brownout_detect_en,
    output reg interrupt_priority_enable,
    output reg irq
);
    // ****************************************************************
    // Register bus access
    // ****************************************************************
    // One wait cycle per access keeps the answer registered.
    reg ack_reg;
    wire acc = (avs_read | avs_write) & ~ack_reg;
    // A write lands at the edge where waitrequest is seen low, when the master completes.
    wire wr = avs_write & ack_reg & avs_byteenable[0];
    wire wr_cause = wr & (avs_address == `RCF_OFF_CAUSE);
    wire wr_clr = wr & (avs_address == `RCF_OFF_IRQ_CLR);
    wire wr_en = wr & (avs_address == `RCF_OFF_IRQ_EN);
    wire [7:0] wd = avs_writedata[7:0];
    wire cfg_sw = (brownout_config_bits == `RCF_BO_CFG_SW);
    // ****************************************************************
    // Cause flags
    // ****************************************************************
    reg prio_reg;
    reg swbo_reg;
    wire ri_f, wdt_f, slp_f, por_f, bo_f;
    // Reset instruction clears, only firmware writes it back.
    rcf_flag #(.RST_VAL(1'b1)) u_ri (
        .clk_sys(clk_sys), .rst(rst), .hw_set(1'b0),
        .hw_clr(reset_instr_evt),
        .sw_we(wr_cause), .sw_val(wd[`RCF_BIT_RI]), .flag_reg(ri_f));
    // Timeout clears; power-up, watchdog clear or sleep set.
    rcf_flag #(.RST_VAL(1'b1)) u_wdt (
        .clk_sys(clk_sys), .rst(rst),
        .hw_set(power_on_evt | watchdog_clear_instr | sleep_instr),
        .hw_clr(watchdog_timeout_evt),
        .sw_we(1'b0), .sw_val(1'b0), .flag_reg(wdt_f));
    // Sleep clears; power-up or watchdog clear sets.
    rcf_flag #(.RST_VAL(1'b1)) u_slp (
        .clk_sys(clk_sys), .rst(rst),
        .hw_set(power_on_evt | watchdog_clear_instr),
        .hw_clr(sleep_instr & ~power_on_evt),
        .sw_we(1'b0), .sw_val(1'b0), .flag_reg(slp_f));
    // Power-on clears it; other resets leave it; rst loads 0 and only software writes it back.
    rcf_flag #(.RST_VAL(1'b0)) u_por (
        .clk_sys(clk_sys), .rst(rst), .hw_set(1'b0),
        .hw_clr(power_on_evt),
        .sw_we(wr_cause), .sw_val(wd[`RCF_BIT_POR]), .flag_reg(por_f));
    // Brown-out or power-on clears; hardware never sets, software writes 1.
    rcf_flag #(.RST_VAL(1'b0)) u_bo (
        .clk_sys(clk_sys), .rst(rst), .hw_set(1'b0),
        .hw_clr(brownout_evt | power_on_evt),
        .sw_we(wr_cause), .sw_val(wd[`RCF_BIT_BO]), .flag_reg(bo_f));
    wire swbo_rd = swbo_reg & cfg_sw;
    wire [7:0] cause = {prio_reg, swbo_rd, 1'b0, ri_f, wdt_f, slp_f, por_f, bo_f};
    // Writable control bits; software enable resets to one.
    always @(posedge clk_sys) begin
        if (rst) begin
            prio_reg <= 1'b0;
            swbo_reg <= 1'b1;
        end else if (wr_cause) begin
            prio_reg <= wd[`RCF_BIT_PRIO];
            swbo_reg <= wd[`RCF_BIT_SWBO];
        end
    end
    // ****************************************************************
    // Interrupts
    // ****************************************************************
    wire [4:0] evts = {reset_instr_evt, watchdog_timeout_evt, sleep_instr,
        power_on_evt, brownout_evt};
    wire [4:0] stat, en;
    wire irq_w;
    rcf_irq #(.W(`RCF_EVT_W)) u_irq (
        .clk_sys(clk_sys), .rst(rst), .evt(evts),
        .clr(wr_clr ? wd[4:0] : 5'h00), .en_we(wr_en), .en_val(wd[4:0]),
        .stat_reg(stat), .en_reg(en), .irq_reg(irq_w));
    // ****************************************************************
    // Outputs and read data
    // ****************************************************************
    reg [7:0] rd_next;
    always @* begin
        case (avs_address)
            `RCF_OFF_CAUSE: rd_next = cause;
            `RCF_OFF_IRQ_STAT: rd_next = {3'h0, stat};
            `RCF_OFF_IRQ_EN: rd_next = {3'h0, en};
            default: rd_next = 8'h00;
        endcase
    end
    // Bus handshake and registered outputs.
    always @(posedge clk_sys) begin
        if (rst) begin
            ack_reg <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h00000000;
            brownout_detect_en <= 1'b0;
            interrupt_priority_enable <= 1'b0;
            irq <= 1'b0;
        end else begin
            ack_reg <= acc;
            avs_waitrequest <= ~acc;
            if (acc) begin
                avs_readdata <= {24'h000000, rd_next};
            end
            brownout_detect_en <= cfg_sw & swbo_reg;
            interrupt_priority_enable <= prio_reg;
            irq <= irq_w;
        end
    end
endmodule
`default_nettype wire

// ==== dv/rcf_sva.sv ====
// Purpose: Port-level checks of the reset-cause flag block.
// Assumes: One clock; rst is synchronous and active high.
// Notes: Flags are seen only through bus reads, so these watch timing.
`timescale 1ns/10ps
`default_nettype none
module rcf_sva (
    input wire clk_sys,
    input wire rst,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire power_on_evt,
    input wire brownout_evt,
    input wire reset_instr_evt,
    input wire watchdog_timeout_evt,
    input wire sleep_instr,
    input wire [1:0] brownout_config_bits,
    input wire brownout_detect_en,
    input wire interrupt_priority_enable,
    input wire irq
);
    // ****************************************
    // Helpers and properties
    // ****************************************
    // Events that land in the status register; irq may only rise after one or after a bus write.
    wire ev = power_on_evt | brownout_evt | reset_instr_evt | watchdog_timeout_evt | sleep_instr;
    wire req = avs_read | avs_write;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    sequence s_asked; req && avs_waitrequest; endsequence
    sequence s_done; ##[1:2] !avs_waitrequest; endsequence
    a_bo_en_cfg: assert property (brownout_detect_en |-> $past(brownout_config_bits) == 2'h1)
        else $error("detector on outside config 01");
    a_bo_en_off: assert property (brownout_config_bits != 2'h1 |=> !brownout_detect_en)
        else $error("detector on with other config");
    a_wait_ack: assert property (s_asked |-> s_done)
        else $error("request not answered");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer held too long");
    a_rd_unmapped: assert property (avs_read && !avs_waitrequest
        && (avs_address == 4'h1 || avs_address > 4'h4) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_irq_rise: assert property ($rose(irq) |-> $past(ev) || $past(ev, 2)
        || $past(avs_write) || $past(avs_write, 2)) else $error("irq rose without cause");
    a_irq_fall: assert property ($fell(irq) |-> $past(avs_write) || $past(avs_write, 2))
        else $error("irq fell without write");
    a_prio_write: assert property ($changed(interrupt_priority_enable) |-> $past(avs_write, 2))
        else $error("priority enable moved without write");
endmodule
`default_nettype wire

// ==== dv/tb.sv ====
// Purpose: Directed bench for the reset-cause flag block.
// Assumes: A write lands at the edge where waitrequest is sampled low.
// Notes: Config 10 hides bit 6 in every read, so expectations omit it.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
    // ****************************************
    // Signals, clock, bus and event tasks
    // ****************************************
    logic clk_sys = 0, rst = 1, avs_read = 0, avs_write = 0;
    logic [3:0] avs_address = 0, avs_byteenable = 4'hf;
    logic [31:0] avs_writedata = 0, q;
    logic [5:0] ev = 0;
    logic [1:0] cfg = 0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, bo_en, prio, irq;
    int fails = 0, n_compared = 0;
    rcf_top dut_u (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .brownout_evt(ev[0]), .power_on_evt(ev[1]),
        .sleep_instr(ev[2]), .watchdog_timeout_evt(ev[3]), .reset_instr_evt(ev[4]),
        .watchdog_clear_instr(ev[5]), .brownout_config_bits(cfg),
        .brownout_detect_en(bo_en), .interrupt_priority_enable(prio), .irq(irq));
    // The clock toggles every 2 ns for a 4 ns period.
    initial forever #2 clk_sys = ~clk_sys;
    // One access; the request stands until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_read <= !wr;
        avs_write <= wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 0;
        avs_write <= 0;
    endtask
    task automatic cause(input logic [7:0] e, input string n);
        bus(0, 4'h0, 8'h0);
        `CHK(n, e, q[7:0])
    endtask
    // Events are one-cycle pulses, as the block expects.
    task automatic pulse(input logic [5:0] m);
        @(posedge clk_sys);
        ev <= m;
        @(posedge clk_sys);
        ev <= 0;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_swbo;
        cause(8'h1c, "reset");
        cfg <= 2'h1;
        cause(8'h5c, "swbo on");
        `CHK("detect on", 1'b1, bo_en)
        bus(1, 4'h0, 8'h13);
        cause(8'h1f, "swbo off");
        `CHK("detect off", 1'b0, bo_en)
        bus(1, 4'h0, 8'h53);
        cfg <= 2'h2;
        cause(8'h1f, "cfg 10");
        `CHK("detect cfg", 1'b0, bo_en)
    endtask
    // Each event moves only its own flags; the table holds the read-back.
    task t_events;
        logic [5:0] m[6] = '{6'h10, 6'h08, 6'h04, 6'h20, 6'h01, 6'h02};
        logic [7:0] e[6] = '{8'h0f, 8'h07, 8'h0b, 8'h0f, 8'h0e, 8'h0c};
        bus(1, 4'h4, 8'h1f);
        for (int i = 0; i < 6; i++) begin
            pulse(m[i]);
            cause(e[i], "event");
            if (i == 4) `CHK("bo inferred", 2'b10, q[1:0])
        end
        bus(1, 4'h0, 8'h13);
        cause(8'h1f, "sw set");
    endtask
    // A write without byte 0 enabled must not clear; masking hides a set bit.
    task t_irq;
        `CHK("irq on", 1'b1, irq)
        avs_byteenable <= 4'h0;
        bus(1, 4'h3, 8'h1f);
        avs_byteenable <= 4'hf;
        bus(0, 4'h2, 8'h0);
        `CHK("stat kept", 8'h1f, q[7:0])
        bus(1, 4'h3, 8'h1f);
        bus(1, 4'h4, 8'h00);
        pulse(6'h01);
        bus(0, 4'h2, 8'h0);
        `CHK("stat masked", 8'h01, q[7:0])
        `CHK("irq masked", 1'b0, irq)
        bus(1, 4'h4, 8'h01);
        bus(0, 4'h1, 8'h0);
        `CHK("irq enabled", 1'b1, irq)
        `CHK("unmapped", 8'h00, q[7:0])
        bus(1, 4'h3, 8'h01);
        bus(0, 4'hf, 8'h0);
        `CHK("irq cleared", 1'b0, irq)
        bus(1, 4'h0, 8'h93);
        cause(8'h9f, "prio");
        `CHK("prio on", 1'b1, prio)
    endtask
    task report_and_stop;
        $display("fails %0d compared %0d", fails, n_compared);
        if (fails == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Main sequence; the watchdog allows 5000 cycles, far more than the roughly 100 used.
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 0;
        t_swbo;
        t_events;
        t_irq;
        report_and_stop;
    end
    initial begin
        #20000;
        fails++;
        report_and_stop;
    end
endmodule
bind rcf_top rcf_sva chk_u (.*);
`default_nettype wire
